/* File: shp_pkg.sv */
// shared constants for the slave host handshake port
// assumes a single 25 MHz core clock
package shp_pkg;
    localparam int REF_CLK_HZ = 25000000;
    localparam int DATA_W = 16;
    // strobe high to ready high, longest, in ns
    localparam int T_READY_MAX_NS = 75;
    // strobe low to data valid, longest, in ns
    localparam int T_DATA_VALID_MAX_NS = 90;
    localparam int CLK_PERIOD_NS = 1000000000 / REF_CLK_HZ;
    localparam int READY_CYC = (T_READY_MAX_NS / CLK_PERIOD_NS) < 1 ? 1 :
        (T_READY_MAX_NS / CLK_PERIOD_NS);
    localparam int DV_CYC = (T_DATA_VALID_MAX_NS / CLK_PERIOD_NS) < 1 ? 1 :
        (T_DATA_VALID_MAX_NS / CLK_PERIOD_NS);
    localparam logic READY_ON = 1'b0;
    localparam logic READY_OFF = 1'b1;
    localparam logic DIR_WRITE = 1'b0;
    localparam logic DIR_READ = 1'b1;
    typedef enum logic [1:0] {
        SHP_IDLE,
        SHP_WRITE,
        SHP_READ
    } shp_state_e;
endpackage

/* File: shp_sync.sv */
// two flop synchroniser for one pin level
// assumes the pin is asynchronous to ref_clk
`timescale 1ns/1ps
`default_nettype none
module shp_sync #(
    parameter logic RST_VAL = 1'b1
) (
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic pin_in,
    output logic pin_sync
);
    logic meta_r;
    logic meta_nxt;
    logic sync_r;
    logic sync_nxt;
    always_comb begin
        meta_nxt = pin_in;
        sync_nxt = meta_r;
    end
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            meta_r <= RST_VAL;
            sync_r <= RST_VAL;
        end else begin
            meta_r <= meta_nxt;
            sync_r <= sync_nxt;
        end
    end
    assign pin_sync = sync_r;
endmodule
`default_nettype wire

/* File: shp_port.sv */
// host handshake port: host writes words in, reads words out
// assumes host pins async to ref_clk; core offers words by load pulses, takes them under a held enable level
//
// Contract
// R1 - ready for a host word: write-ready driven low
// R2 - host write: direction low, strobe low, then data on the bus
// R3 - host raises strobe only once its write data is valid
// R4 - on strobe rise in write, capture bus word, write-ready back high
// R5 - write-ready rising edge pulses the write-complete interrupt
// R6 - word held for host: read-ready driven low
// R7 - read with direction high: drive outgoing word while strobe low
// R8 - host read: direction high, strobe low, raise strobe after sampling
// R9 - on strobe rise in read, read-ready high and read-complete interrupt
// R10 - drive bus only in read while strobe low, release after strobe rise
`timescale 1ns/1ps
`default_nettype none
module shp_port #(
    parameter int DATA_W = shp_pkg::DATA_W
) (
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic host_dir_read,
    input wire logic host_strobe_n,
    input wire logic [DATA_W-1:0] host_data_in,
    output logic [DATA_W-1:0] host_data_out,
    output logic host_data_oe,
    output logic host_write_ready_n,
    output logic host_read_ready_n,
    input wire logic core_rx_enable,
    output logic [DATA_W-1:0] core_rx_data,
    input wire logic core_tx_load,
    input wire logic [DATA_W-1:0] core_tx_data,
    output logic core_tx_empty,
    output logic write_complete_irq,
    output logic read_complete_irq
);
    // idle levels of the host pins, loaded into their synchronisers at reset
    localparam logic STROBE_IDLE = 1'h1;
    localparam logic DATA_IDLE = 1'h0;

    // pin side, each through two flops before any logic reads it
    logic dir_s;
    logic strobe_s;
    logic [DATA_W-1:0] data_s;

    // handshake state
    shp_pkg::shp_state_e state_r;
    shp_pkg::shp_state_e state_nxt;
    logic strobe_prev_r;
    logic strobe_prev_nxt;

    // write direction: host to core
    logic wr_rdy_r;
    logic wr_rdy_nxt;
    logic rx_hold_r;
    logic rx_hold_nxt;
    logic [DATA_W-1:0] rx_data_r;
    logic [DATA_W-1:0] rx_data_nxt;

    // read direction: core to host
    logic rd_rdy_r;
    logic rd_rdy_nxt;
    logic [DATA_W-1:0] tx_data_r;
    logic [DATA_W-1:0] tx_data_nxt;

    // interrupt edge detect
    logic wr_rdy_prev_r;
    logic wr_rdy_prev_nxt;
    logic rd_rdy_prev_r;
    logic rd_rdy_prev_nxt;
    logic wr_irq_r;
    logic wr_irq_nxt;
    logic rd_irq_r;
    logic rd_irq_nxt;

    // decoded events
    logic strobe_fall;
    logic strobe_rise;
    logic wr_take;
    logic rd_take;
    logic wr_arm;
    logic tx_accept;

    // direction idles high, the same as a host at rest
    shp_sync #(
        .RST_VAL(shp_pkg::DIR_READ)
    ) dir_sync_i (
        .ref_clk(ref_clk),
        .rst_b(rst_b),
        .pin_in(host_dir_read),
        .pin_sync(dir_s)
    );

    // strobe flops reset high, so no false edge follows reset
    shp_sync #(
        .RST_VAL(STROBE_IDLE)
    ) strobe_sync_i (
        .ref_clk(ref_clk),
        .rst_b(rst_b),
        .pin_in(host_strobe_n),
        .pin_sync(strobe_s)
    );

    // bus bits share the strobe's latency, so the word and the edge line up;
    // safe only because the host holds the word well past the strobe rise
    genvar bit_idx;
    generate
        for (bit_idx = 0; bit_idx < DATA_W; bit_idx++) begin : data_sync_g
            shp_sync #(
                .RST_VAL(DATA_IDLE)
            ) shp_sync_i (
                .ref_clk(ref_clk),
                .rst_b(rst_b),
                .pin_in(host_data_in[bit_idx]),
                .pin_sync(data_s[bit_idx])
            );
        end
    endgenerate

    always_comb begin
        strobe_fall = strobe_prev_r && !strobe_s;
        strobe_rise = !strobe_prev_r && strobe_s;
        wr_take = strobe_rise &&
            (state_r == shp_pkg::SHP_WRITE) &&
            (wr_rdy_r == shp_pkg::READY_ON);
        rd_take = strobe_rise &&
            (state_r == shp_pkg::SHP_READ) &&
            (rd_rdy_r == shp_pkg::READY_ON);
        // re-arm only after the core drops enable, so one word per offer
        wr_arm = core_rx_enable && !rx_hold_r &&
            (wr_rdy_r == shp_pkg::READY_OFF) &&
            (state_r == shp_pkg::SHP_IDLE);
        // a load during a host read is ignored: the word on the bus must hold
        tx_accept = core_tx_load && (state_r != shp_pkg::SHP_READ);
    end

    always_comb begin
        state_nxt = state_r;
        strobe_prev_nxt = strobe_s;
        case (state_r)
            shp_pkg::SHP_IDLE: begin
                if (strobe_fall) begin
                    if (dir_s == shp_pkg::DIR_READ) begin
                        state_nxt = shp_pkg::SHP_READ;
                    end else begin
                        state_nxt = shp_pkg::SHP_WRITE;
                    end
                end
            end
            shp_pkg::SHP_WRITE: begin
                if (strobe_rise) begin
                    state_nxt = shp_pkg::SHP_IDLE;
                end
            end
            shp_pkg::SHP_READ: begin
                if (strobe_rise) begin
                    state_nxt = shp_pkg::SHP_IDLE; // R10
                end
            end
            default: begin
                state_nxt = shp_pkg::SHP_IDLE;
            end
        endcase
    end

    always_comb begin
        wr_rdy_nxt = wr_rdy_r;
        rx_hold_nxt = rx_hold_r;
        rx_data_nxt = rx_data_r;
        if (!core_rx_enable) begin
            rx_hold_nxt = 1'h0;
        end
        if (wr_arm) begin
            wr_rdy_nxt = shp_pkg::READY_ON; // R1
        end
        if (wr_take) begin
            rx_data_nxt = data_s; // R4
            wr_rdy_nxt = shp_pkg::READY_OFF; // R4
            // set wins over a release in the same cycle
            rx_hold_nxt = 1'h1;
        end
    end

    always_comb begin
        rd_rdy_nxt = rd_rdy_r;
        tx_data_nxt = tx_data_r;
        if (tx_accept) begin
            tx_data_nxt = core_tx_data;
            rd_rdy_nxt = shp_pkg::READY_ON; // R6
        end
        if (rd_take) begin
            rd_rdy_nxt = shp_pkg::READY_OFF; // R9
        end
    end

    // ready resets off and so does its copy: no interrupt out of reset
    always_comb begin
        wr_rdy_prev_nxt = wr_rdy_r;
        rd_rdy_prev_nxt = rd_rdy_r;
        wr_irq_nxt = (wr_rdy_r == shp_pkg::READY_OFF) &&
            (wr_rdy_prev_r == shp_pkg::READY_ON); // R5
        rd_irq_nxt = (rd_rdy_r == shp_pkg::READY_OFF) &&
            (rd_rdy_prev_r == shp_pkg::READY_ON); // R9
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            state_r <= shp_pkg::SHP_IDLE;
            strobe_prev_r <= STROBE_IDLE;
            wr_rdy_r <= shp_pkg::READY_OFF;
            rx_hold_r <= 1'h0;
            rx_data_r <= '0;
            rd_rdy_r <= shp_pkg::READY_OFF;
            tx_data_r <= '0;
            wr_rdy_prev_r <= shp_pkg::READY_OFF;
            rd_rdy_prev_r <= shp_pkg::READY_OFF;
            wr_irq_r <= 1'h0;
            rd_irq_r <= 1'h0;
        end else begin
            state_r <= state_nxt;
            strobe_prev_r <= strobe_prev_nxt;
            wr_rdy_r <= wr_rdy_nxt;
            rx_hold_r <= rx_hold_nxt;
            rx_data_r <= rx_data_nxt;
            rd_rdy_r <= rd_rdy_nxt;
            tx_data_r <= tx_data_nxt;
            wr_rdy_prev_r <= wr_rdy_prev_nxt;
            rd_rdy_prev_r <= rd_rdy_prev_nxt;
            wr_irq_r <= wr_irq_nxt;
            rd_irq_r <= rd_irq_nxt;
        end
    end

    // limitation: pin synchronising costs about three clocks each way,
    // so at this clock the host sees ready and data later than it may expect
    assign host_write_ready_n = wr_rdy_r;
    assign host_read_ready_n = rd_rdy_r;
    assign core_rx_data = rx_data_r;
    assign core_tx_empty = (rd_rdy_r == shp_pkg::READY_OFF);
    assign host_data_out = tx_data_r; // R7
    assign host_data_oe = (state_r == shp_pkg::SHP_READ) && !strobe_s &&
        (rd_rdy_r == shp_pkg::READY_ON); // R7 R10
    assign write_complete_irq = wr_irq_r;
    assign read_complete_irq = rd_irq_r;

    default clocking chk_cb @(posedge ref_clk);
    endclocking
    default disable iff (!rst_b);

    sequence s_write_close;
        (host_write_ready_n == shp_pkg::READY_OFF) &&
            (core_rx_data == $past(data_s)) ##1 write_complete_irq;
    endsequence

    sequence s_read_close;
        (host_read_ready_n == shp_pkg::READY_OFF) && !host_data_oe ##1
            read_complete_irq;
    endsequence

    chk_write_arm: assert property ( // R1
        wr_arm |=> (host_write_ready_n == shp_pkg::READY_ON))
        else $error("write ready not offered");

    chk_write_close: assert property ( // R4
        wr_take |=> s_write_close)
        else $error("write word not captured or ready not returned");

    chk_write_irq_edge: assert property ( // R5
        $rose(host_write_ready_n) |=> write_complete_irq)
        else $error("write ready rise gave no interrupt");

    chk_write_irq_single: assert property ( // R5
        write_complete_irq |=> !write_complete_irq)
        else $error("write interrupt longer than one cycle");

    chk_tx_offer: assert property ( // R6
        tx_accept |=> (host_read_ready_n == shp_pkg::READY_ON) && !core_tx_empty)
        else $error("read ready not offered after load");

    chk_read_drive: assert property ( // R7
        ($fell(strobe_s) && (dir_s == shp_pkg::DIR_READ) &&
            (state_r == shp_pkg::SHP_IDLE) &&
            (host_read_ready_n == shp_pkg::READY_ON)) |=> host_data_oe)
        else $error("read word not driven while strobe low");

    chk_read_close: assert property ( // R9
        rd_take |=> s_read_close)
        else $error("read ready or read interrupt missing");

    chk_bus_release: assert property ( // R10
        $rose(strobe_s) |-> !host_data_oe)
        else $error("bus still driven after strobe rise");

    chk_bus_only_read: assert property ( // R10
        host_data_oe |-> !strobe_s && (state_r == shp_pkg::SHP_READ))
        else $error("bus driven outside a read");
endmodule
`default_nettype wire

/* File: shp_host.sv */
// host model: drives direction, strobe and write data
// assumes tb supplies clk and calls go then up for each transfer
`timescale 1ns/1ps
`default_nettype none
module shp_host (
    output logic dir,
    output logic stb_n,
    output logic [15:0] d,
    input wire logic clk
);
initial begin dir=1; stb_n=1; d=0; end
task automatic go(input logic rd, input logic [15:0] w);
    @(negedge clk) dir=rd;
    repeat(2) @(negedge clk);
    stb_n=0;
    @(negedge clk) if (!rd) d=w;
    repeat(8) @(negedge clk);
endtask
task automatic up;
    stb_n=1;
    repeat(2) @(negedge clk);
    d=~d; // hold over, bus no longer valid
endtask
endmodule
`default_nettype wire

/* File: tb.sv */
// self-checking bench for shp_port
// assumes shp_host as the far side
`timescale 1ns/1ps
`default_nettype none
module tb;
logic clk=0, rst_b=0, en=0, ld=0, dr, sn, ws=0, rs=0;
logic [15:0] hd, rx, dout, td=16'hA5C3;
wire oe, wr, rr, te, wi, ri;
int bad_count=0, tests_run=0;
shp_host shp_host_i(.dir(dr), .stb_n(sn), .d(hd), .clk(clk));
shp_port shp_port_i(.ref_clk(clk), .rst_b(rst_b), .host_dir_read(dr), .host_strobe_n(sn),
    .host_data_in(hd), .host_data_out(dout), .host_data_oe(oe), .host_write_ready_n(wr),
    .host_read_ready_n(rr), .core_rx_enable(en), .core_rx_data(rx), .core_tx_load(ld),
    .core_tx_data(td), .core_tx_empty(te), .write_complete_irq(wi), .read_complete_irq(ri));
initial forever #20 clk=~clk;
always @(posedge clk) begin ws<=ws|(wi===1); rs<=rs|(ri===1); end
task chk(input logic [15:0] s, e);
    tests_run++;
    if (s!==e) begin bad_count++; $display("CHECK FAILED %0t %h %h", $time, s, e); end
endtask
task give_verdict;
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count==0 && tests_run>0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
endtask
initial begin
    repeat(10) @(negedge clk);
    rst_b=1; en=1;
    for (int i=0; i<50 && wr!==0; i++) @(negedge clk);
    chk(wr, 0);
    shp_host_i.go(0, 16'h3C5A);
    shp_host_i.up;
    for (int i=0; i<20 && wr!==1; i++) @(negedge clk);
    repeat(3) @(negedge clk);
    chk(wr, 1); chk(rx, 16'h3C5A); chk(ws, 1);
    en=0;
    $display("write test done");
    ld=1;
    @(negedge clk) ld=0;
    for (int i=0; i<50 && rr!==0; i++) @(negedge clk);
    chk(rr, 0); chk(te, 0);
    shp_host_i.go(1, 16'h0F0F);
    chk(oe, 1); chk(dout, td);
    shp_host_i.up;
    for (int i=0; i<20 && rr!==1; i++) @(negedge clk);
    repeat(3) @(negedge clk);
    chk(rr, 1); chk(rs, 1); chk(oe, 0); chk(te, 1);
    $display("read test done");
    give_verdict;
end
endmodule
`default_nettype wire
